// ### rtl/mprb_pkg.sv
// constants shared by the peripheral register bank
// assumes a 32-bit apb slave, one register per word, index = byte address / 4
package mprb_pkg;
	localparam logic [7:0] IDX_CSIO_CTRL = 8'h0a;
	localparam logic [7:0] IDX_TMR_CTRL = 8'h10;
	localparam logic [7:0] IDX_T1_CNT_L = 8'h14;
	localparam logic [7:0] IDX_T1_CNT_H = 8'h15;
	localparam logic [7:0] IDX_T1_RLD_L = 8'h16;
	localparam logic [7:0] IDX_T1_RLD_H = 8'h17;
	localparam logic [7:0] IDX_FRC = 8'h18;
	localparam logic [7:0] IDX_CPU_CTRL = 8'h1f;
	localparam logic [7:0] IDX_D0_SRC_B = 8'h22;
	localparam logic [7:0] IDX_D0_DST_L = 8'h23;
	localparam logic [7:0] IDX_D0_DST_H = 8'h24;
	localparam logic [7:0] IDX_D0_DST_B = 8'h25;
	localparam logic [7:0] IDX_D0_CNT_L = 8'h26;
	localparam logic [7:0] IDX_D0_CNT_H = 8'h27;
	localparam logic [7:0] IDX_D1_MEM_L = 8'h28;
	localparam logic [7:0] IDX_D1_MEM_H = 8'h29;
	localparam logic [7:0] IDX_D1_MEM_B = 8'h2a;
	localparam logic [7:0] IDX_D1_IO_L = 8'h2b;
	localparam logic [7:0] IDX_D1_IO_H = 8'h2c;
	localparam logic [7:0] IDX_D1_CNT_L = 8'h2e;
	localparam logic [7:0] IDX_D1_CNT_H = 8'h2f;
	localparam logic [7:0] IDX_D1_MODE = 8'h31;
	localparam logic [7:0] IDX_REFRESH = 8'h36;
	// field positions
	localparam int TMR_EN_BIT = 1;
	localparam int TOC_LO_BIT = 6;
	localparam int REF_EN_BIT = 7;
	localparam int D1_EN_BIT = 7;
	// reset values
	localparam logic [7:0] CPU_CTRL_RST = 8'h00;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [15:0] CNT_RST = 16'hffff;
	// serial clock dividers for codes 000..110
	localparam int SER_DIV_0 = 20;
	localparam int SER_DIV_1 = 40;
	localparam int SER_DIV_2 = 80;
	localparam int SER_DIV_3 = 100;
	localparam int SER_DIV_4 = 320;
	localparam int SER_DIV_5 = 640;
	localparam int SER_DIV_6 = 1280;
	// refresh intervals in states for codes 00..11
	localparam int REF_INT_0 = 10;
	localparam int REF_INT_1 = 20;
	localparam int REF_INT_2 = 40;
	localparam int REF_INT_3 = 80;
	// timers and the free running counter advance once every this many clocks
	localparam int TMR_PRESCALE = 20;
endpackage

// ### rtl/mprb_top.sv
// peripheral register bank of an embedded processor core, with apb access
// assumes one clock pclk; pin inputs already synchronous to pclk
// Function
// - serial shift clock divides system clock by 20..1280, code 111 external
// - timer 1 has a readable, writable 16-bit reload split in two bytes
// - free running counter is an 8-bit read-only register at 18H
// - cpu control register sits at 1FH and resets to all zeros
// - channel 0 source bank bits 17:16 pick request: pin, serial0 rx, serial1 rx
// - channel 0 dest bank bits 17:16 pick request: pin, serial0 tx, serial1 tx
// - channel 0 bank registers implement bits 0-2 only, top of 20-bit address
// - channel 1 mode sets direction and memory step; io address fixed
// - refresh interval field picks 10, 20, 40 or 80 states between refreshes
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module mprb_top #(
	parameter int DATA_W = 8,
	parameter int FIFO_DEPTH = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_serial_clk,
	output logic serial_clk,
	output logic shared_addr_timer_pin,
	output logic shared_addr_timer_oe,
	output logic refresh_req,
	input wire logic external_transfer_request,
	input wire logic serial0_receive_data,
	input wire logic serial1_receive_data,
	input wire logic serial0_transmit_data,
	input wire logic serial1_transmit_data,
	output logic ch0_src_req,
	output logic ch0_dst_req,
	output logic [19:0] ch0_dest_addr,
	output logic [15:0] ch0_count,
	output logic [7:0] cpu_control_register,
	input wire logic [DATA_W-1:0] ch1_in_data,
	input wire logic ch1_in_valid,
	output logic ch1_in_ready,
	output logic [DATA_W-1:0] ch1_out_data,
	output logic [19:0] ch1_out_addr,
	output logic ch1_out_valid,
	input wire logic ch1_out_ready,
	output logic ch1_to_memory,
	output logic [15:0] ch1_io_address
);
	function automatic logic [7:0] byte_of(input logic [15:0] v, input logic hi);
		byte_of = hi ? v[15:8] : v[7:0];
	endfunction

	function automatic logic [15:0] set_byte(input logic [15:0] v, input logic hi,
			input logic [7:0] b);
		set_byte = hi ? {b, v[7:0]} : {v[15:8], b};
	endfunction

	// apb decode
	wire logic setup = psel && !penable;
	wire logic wr_done = psel && penable && pready && pwrite;
	wire logic [7:0] idx = paddr[9:2];
	wire logic [7:0] wb = pwdata[7:0];
	// two byte pairs start on an odd index, so their low half sits at the odd one
	wire logic wr_hi = idx[0] ^ (idx == mprb_pkg::IDX_D0_DST_L
		|| idx == mprb_pkg::IDX_D0_DST_H || idx == mprb_pkg::IDX_D1_IO_L
		|| idx == mprb_pkg::IDX_D1_IO_H);

	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [2:0] ss_q;
	logic [7:0] tctrl_q;
	logic [15:0] t1_cnt_q;
	logic [15:0] t1_rld_q;
	logic [7:0] t1_hi_hold_q;
	logic [7:0] frc_q;
	logic [7:0] ccr_q;
	logic [2:0] d0_src_b_q;
	logic [15:0] d0_dst_q;
	logic [2:0] d0_dst_b_q;
	logic [15:0] d0_cnt_q;
	logic [15:0] d1_mem_q;
	logic [3:0] d1_mem_b_q;
	logic [15:0] d1_io_q;
	logic [15:0] d1_cnt_q;
	logic [7:0] d1_mode_q;
	logic [7:0] refresh_q;
	logic [10:0] ser_cnt_q;
	logic serial_clk_q;
	logic [4:0] pre_cnt_q;
	logic tout_q;
	logic [6:0] ref_cnt_q;
	logic refresh_req_q;
	logic ch0_src_req_q;
	logic ch0_dst_req_q;

	// read decode, one word per register, narrower data in the low bits
	logic [7:0] rd_byte;
	logic rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		case (idx)
			mprb_pkg::IDX_CSIO_CTRL: rd_byte = {5'h00, ss_q};
			mprb_pkg::IDX_TMR_CTRL: rd_byte = tctrl_q;
			mprb_pkg::IDX_T1_CNT_L: rd_byte = byte_of(t1_cnt_q, 1'b0);
			mprb_pkg::IDX_T1_CNT_H: rd_byte = t1_hi_hold_q;
			mprb_pkg::IDX_T1_RLD_L: rd_byte = byte_of(t1_rld_q, 1'b0);
			mprb_pkg::IDX_T1_RLD_H: rd_byte = byte_of(t1_rld_q, 1'b1);
			mprb_pkg::IDX_FRC: rd_byte = frc_q;
			mprb_pkg::IDX_CPU_CTRL: rd_byte = ccr_q;
			mprb_pkg::IDX_D0_SRC_B: rd_byte = {5'h00, d0_src_b_q};
			mprb_pkg::IDX_D0_DST_L: rd_byte = byte_of(d0_dst_q, 1'b0);
			mprb_pkg::IDX_D0_DST_H: rd_byte = byte_of(d0_dst_q, 1'b1);
			mprb_pkg::IDX_D0_DST_B: rd_byte = {5'h00, d0_dst_b_q};
			mprb_pkg::IDX_D0_CNT_L: rd_byte = byte_of(d0_cnt_q, 1'b0);
			mprb_pkg::IDX_D0_CNT_H: rd_byte = byte_of(d0_cnt_q, 1'b1);
			mprb_pkg::IDX_D1_MEM_L: rd_byte = byte_of(d1_mem_q, 1'b0);
			mprb_pkg::IDX_D1_MEM_H: rd_byte = byte_of(d1_mem_q, 1'b1);
			mprb_pkg::IDX_D1_MEM_B: rd_byte = {4'h0, d1_mem_b_q};
			mprb_pkg::IDX_D1_IO_L: rd_byte = byte_of(d1_io_q, 1'b0);
			mprb_pkg::IDX_D1_IO_H: rd_byte = byte_of(d1_io_q, 1'b1);
			mprb_pkg::IDX_D1_CNT_L: rd_byte = byte_of(d1_cnt_q, 1'b0);
			mprb_pkg::IDX_D1_CNT_H: rd_byte = byte_of(d1_cnt_q, 1'b1);
			mprb_pkg::IDX_D1_MODE: rd_byte = d1_mode_q;
			mprb_pkg::IDX_REFRESH: rd_byte = refresh_q;
			default: begin
				rd_byte = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	wire logic hit_wr = wr_done && !pslverr_q;
	wire logic w_t1l = hit_wr && idx == mprb_pkg::IDX_T1_CNT_L;
	wire logic w_t1h = hit_wr && idx == mprb_pkg::IDX_T1_CNT_H;
	wire logic rd_t1l = setup && !pwrite && idx == mprb_pkg::IDX_T1_CNT_L;

	// one wait-free access: answer registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !rd_hit;
			if (setup && !pwrite)
				prdata_q <= {24'h00_0000, rd_byte};
		end
	end

	// low-byte read freezes the high byte so a 16-bit read stays coherent
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			t1_hi_hold_q <= mprb_pkg::REG_RST;
		else if (rd_t1l)
			t1_hi_hold_q <= byte_of(t1_cnt_q, 1'b1);
	end

	// plain software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ss_q <= 3'h0;
			tctrl_q <= mprb_pkg::REG_RST;
			t1_rld_q <= mprb_pkg::CNT_RST;
			ccr_q <= mprb_pkg::CPU_CTRL_RST;
			d0_src_b_q <= 3'h0;
			d0_dst_b_q <= 3'h0;
			d0_dst_q <= 16'h0000;
			d0_cnt_q <= 16'h0000;
			d1_io_q <= 16'h0000;
			d1_mode_q <= mprb_pkg::REG_RST;
			refresh_q <= mprb_pkg::REG_RST;
		end else if (hit_wr) begin
			case (idx)
				mprb_pkg::IDX_CSIO_CTRL: ss_q <= wb[2:0];
				mprb_pkg::IDX_TMR_CTRL: tctrl_q <= wb;
				mprb_pkg::IDX_T1_RLD_L,
				mprb_pkg::IDX_T1_RLD_H: t1_rld_q <= set_byte(t1_rld_q, wr_hi, wb);
				mprb_pkg::IDX_CPU_CTRL: ccr_q <= wb;
				mprb_pkg::IDX_D0_SRC_B: d0_src_b_q <= wb[2:0];
				mprb_pkg::IDX_D0_DST_B: d0_dst_b_q <= wb[2:0];
				mprb_pkg::IDX_D0_DST_L,
				mprb_pkg::IDX_D0_DST_H: d0_dst_q <= set_byte(d0_dst_q, wr_hi, wb);
				mprb_pkg::IDX_D0_CNT_L,
				mprb_pkg::IDX_D0_CNT_H: d0_cnt_q <= set_byte(d0_cnt_q, wr_hi, wb);
				mprb_pkg::IDX_D1_IO_L,
				mprb_pkg::IDX_D1_IO_H: d1_io_q <= set_byte(d1_io_q, wr_hi, wb);
				mprb_pkg::IDX_D1_MODE: d1_mode_q <= wb;
				mprb_pkg::IDX_REFRESH: refresh_q <= wb;
				default: ;
			endcase
		end
	end

	// serial shift clock: half-period count, external clock passed through
	logic [10:0] ser_half;
	always_comb begin
		case (ss_q)
			3'h0: ser_half = 11'(mprb_pkg::SER_DIV_0 / 2);
			3'h1: ser_half = 11'(mprb_pkg::SER_DIV_1 / 2);
			3'h2: ser_half = 11'(mprb_pkg::SER_DIV_2 / 2);
			3'h3: ser_half = 11'(mprb_pkg::SER_DIV_3 / 2);
			3'h4: ser_half = 11'(mprb_pkg::SER_DIV_4 / 2);
			3'h5: ser_half = 11'(mprb_pkg::SER_DIV_5 / 2);
			3'h6: ser_half = 11'(mprb_pkg::SER_DIV_6 / 2);
			default: ser_half = 11'h001;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ser_cnt_q <= 11'h000;
			serial_clk_q <= 1'b0;
		end else if (ss_q == 3'h7) begin
			ser_cnt_q <= 11'h000;
			serial_clk_q <= ext_serial_clk;
		end else if (ser_cnt_q + 11'h001 >= ser_half) begin
			ser_cnt_q <= 11'h000;
			serial_clk_q <= !serial_clk_q;
		end else begin
			ser_cnt_q <= ser_cnt_q + 11'h001;
		end
	end

	// timer and free running counter advance on a shared prescaled tick
	wire logic tick = pre_cnt_q == 5'(mprb_pkg::TMR_PRESCALE - 1);
	wire logic t1_run = tctrl_q[mprb_pkg::TMR_EN_BIT];
	wire logic t1_zero = t1_run && tick && t1_cnt_q == 16'h0000;
	wire logic [1:0] toc = tctrl_q[mprb_pkg::TOC_LO_BIT +: 2];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt_q <= 5'h00;
			frc_q <= 8'hff;
		end else begin
			pre_cnt_q <= tick ? 5'h00 : pre_cnt_q + 5'h01;
			if (tick)
				frc_q <= frc_q - 8'h01;
		end
	end

	// a software write to the count wins over the countdown in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			t1_cnt_q <= mprb_pkg::CNT_RST;
		else if (w_t1l || w_t1h)
			t1_cnt_q <= set_byte(t1_cnt_q, w_t1h, wb);
		else if (t1_zero)
			t1_cnt_q <= t1_rld_q;
		else if (t1_run && tick)
			t1_cnt_q <= t1_cnt_q - 16'h0001;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tout_q <= 1'b0;
		else if (toc == 2'h1 && t1_zero)
			tout_q <= !tout_q;
		else if (toc[1])
			tout_q <= toc[0];
	end

	// refresh request pulse every 10/20/40/80 states
	logic [6:0] ref_int;
	always_comb begin
		case (refresh_q[1:0])
			2'h0: ref_int = 7'(mprb_pkg::REF_INT_0);
			2'h1: ref_int = 7'(mprb_pkg::REF_INT_1);
			2'h2: ref_int = 7'(mprb_pkg::REF_INT_2);
			default: ref_int = 7'(mprb_pkg::REF_INT_3);
		endcase
	end

	wire logic ref_hit = ref_cnt_q + 7'h01 >= ref_int;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_cnt_q <= 7'h00;
			refresh_req_q <= 1'b0;
		end else begin
			ref_cnt_q <= ref_hit ? 7'h00 : ref_cnt_q + 7'h01;
			refresh_req_q <= ref_hit && refresh_q[mprb_pkg::REF_EN_BIT];
		end
	end

	// channel 0 request source selection
	function automatic logic pick_req(input logic [1:0] sel, input logic a,
			input logic b);
		case (sel)
			2'h0: pick_req = external_transfer_request;
			2'h1: pick_req = a;
			2'h2: pick_req = b;
			default: pick_req = 1'b0;
		endcase
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch0_src_req_q <= 1'b0;
			ch0_dst_req_q <= 1'b0;
		end else begin
			ch0_src_req_q <= pick_req(d0_src_b_q[1:0], serial0_receive_data,
				serial1_receive_data);
			ch0_dst_req_q <= pick_req(d0_dst_b_q[1:0], serial0_transmit_data,
				serial1_transmit_data);
		end
	end

	// channel 1: two-entry buffer between the io side and the memory side
	logic [DATA_W-1:0] buf_q [FIFO_DEPTH];
	logic [19:0] badr_q [FIFO_DEPTH];
	logic [$clog2(FIFO_DEPTH)-1:0] wp_q;
	logic [$clog2(FIFO_DEPTH)-1:0] rp_q;
	logic [$clog2(FIFO_DEPTH):0] lvl_q;
	logic in_ready_q;
	wire logic d1_on = d1_mode_q[mprb_pkg::D1_EN_BIT] && d1_cnt_q != 16'h0000;
	wire logic push = ch1_in_valid && in_ready_q && d1_on;
	wire logic pop = lvl_q != '0 && ch1_out_ready;
	wire logic [1:0] dm = d1_mode_q[1:0];
	wire logic [$clog2(FIFO_DEPTH):0] lvl_d = lvl_q + push - pop;
	wire logic w_mem = hit_wr && (idx == mprb_pkg::IDX_D1_MEM_L
		|| idx == mprb_pkg::IDX_D1_MEM_H);

	// ready is registered, so it looks at the level after this cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_q <= '0;
			rp_q <= '0;
			lvl_q <= '0;
			in_ready_q <= 1'b0;
		end else begin
			wp_q <= push ? wp_q + 1'b1 : wp_q;
			rp_q <= pop ? rp_q + 1'b1 : rp_q;
			lvl_q <= lvl_d;
			in_ready_q <= lvl_d < FIFO_DEPTH;
		end
	end

	always_ff @(posedge pclk) begin
		if (push) begin
			buf_q[wp_q] <= ch1_in_data;
			badr_q[wp_q] <= {d1_mem_b_q, d1_mem_q};
		end
	end

	// memory address steps per accepted word; io address never moves
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			d1_mem_q <= 16'h0000;
			d1_mem_b_q <= 4'h0;
			d1_cnt_q <= 16'h0000;
		end else begin
			if (w_mem)
				d1_mem_q <= set_byte(d1_mem_q, wr_hi, wb);
			else if (hit_wr && idx == mprb_pkg::IDX_D1_MEM_B)
				d1_mem_b_q <= wb[3:0];
			else if (push)
				{d1_mem_b_q, d1_mem_q} <= dm[0] ? {d1_mem_b_q, d1_mem_q} - 20'h00001
					: {d1_mem_b_q, d1_mem_q} + 20'h00001;
			if (hit_wr && (idx == mprb_pkg::IDX_D1_CNT_L
					|| idx == mprb_pkg::IDX_D1_CNT_H))
				d1_cnt_q <= set_byte(d1_cnt_q, idx[0], wb);
			else if (push)
				d1_cnt_q <= d1_cnt_q - 16'h0001;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign serial_clk = serial_clk_q;
	assign shared_addr_timer_pin = tout_q;
	assign shared_addr_timer_oe = toc != 2'h0;
	assign refresh_req = refresh_req_q;
	assign ch0_src_req = ch0_src_req_q;
	assign ch0_dst_req = ch0_dst_req_q;
	assign ch0_dest_addr = {1'b0, d0_dst_b_q, d0_dst_q};
	assign ch0_count = d0_cnt_q;
	assign cpu_control_register = ccr_q;
	assign ch1_in_ready = in_ready_q && d1_on;
	assign ch1_out_data = buf_q[rp_q];
	assign ch1_out_addr = badr_q[rp_q];
	assign ch1_out_valid = lvl_q != '0;
	assign ch1_to_memory = dm[1];
	assign ch1_io_address = d1_io_q;
endmodule

// ### testbench/mprb_checker.sv
// concurrent checks on the ports of the peripheral register bank
// assumes a single pclk domain with presetn as its asynchronous reset
`timescale 1ns/1ps
module mprb_checker #(
	parameter int DATA_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic shared_addr_timer_pin,
	input wire logic shared_addr_timer_oe,
	input wire logic refresh_req,
	input wire logic [19:0] ch0_dest_addr,
	input wire logic [7:0] cpu_control_register,
	input wire logic [DATA_W-1:0] ch1_out_data,
	input wire logic [19:0] ch1_out_addr,
	input wire logic ch1_out_valid,
	input wire logic ch1_out_ready
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	setup_gets_ready_a: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	ready_has_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
		else $error("pready without setup");
	error_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr outside access");
	read_upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	pin_inhibit_hold_a: assert property (
		!shared_addr_timer_oe ##1 !shared_addr_timer_oe |-> $stable(shared_addr_timer_pin))
		else $error("timer pin moved while inhibited");
	refresh_min_gap_a: assert property (refresh_req |=> !refresh_req [*8])
		else $error("refresh pulses too close");
	stall_holds_word_a: assert property (ch1_out_valid && !ch1_out_ready |=>
		ch1_out_valid && $stable(ch1_out_data) && $stable(ch1_out_addr))
		else $error("stalled word changed");
	dest_top_zero_a: assert property (ch0_dest_addr[19] == 1'b0)
		else $error("unimplemented bank bit set");
	ctrl_reset_zero_a: assert property ($rose(presetn) |-> cpu_control_register == 8'h00)
		else $error("cpu control not zero after reset");
endmodule

// ### testbench/mpu_peripheral_register_map_test.sv
// self-checking bench for the peripheral register bank
// drives apb, request pins and the channel 1 stream itself from one pclk
`timescale 1ns/1ps
module mpu_peripheral_register_map_test;
	logic pclk, presetn, psel, penable, pwrite, ext_serial_clk, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic serial_clk, pin, oe, refresh_req, ext_req, s0rx, s1rx, s0tx, s1tx, src_req, dst_req;
	logic [19:0] dest_addr, out_addr;
	logic [15:0] cnt, io_addr;
	logic [7:0] cpu_ctrl, in_data, out_data, rd, f, g;
	logic [2:0] v;
	logic in_valid, in_ready, out_valid, out_ready, to_mem, err;
	int failures, checked, d;
	int divs[7] = '{20, 40, 80, 100, 320, 640, 1280};
	mprb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_serial_clk(ext_serial_clk), .serial_clk(serial_clk),
		.shared_addr_timer_pin(pin), .shared_addr_timer_oe(oe), .refresh_req(refresh_req),
		.external_transfer_request(ext_req), .serial0_receive_data(s0rx),
		.serial1_receive_data(s1rx), .serial0_transmit_data(s0tx),
		.serial1_transmit_data(s1tx), .ch0_src_req(src_req), .ch0_dst_req(dst_req),
		.ch0_dest_addr(dest_addr), .ch0_count(cnt), .cpu_control_register(cpu_ctrl),
		.ch1_in_data(in_data), .ch1_in_valid(in_valid), .ch1_in_ready(in_ready),
		.ch1_out_data(out_data), .ch1_out_addr(out_addr), .ch1_out_valid(out_valid),
		.ch1_out_ready(out_ready), .ch1_to_memory(to_mem), .ch1_io_address(io_addr));
	task automatic conclude;
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic stall;
		failures++;
		conclude();
	endtask
	task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// the slave latency is not assumed: the access phase lasts until pready
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			stall();
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one more edge so the written value has reached the outputs before a compare
	task automatic wr(input logic [7:0] idx, input logic [7:0] val);
		xfer(1'b1, idx, val);
		@(posedge pclk);
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		check($sformatf("reg %h", idx), rd, exp);
	endtask
	// three edges: the first interval may still run on the old setting
	task automatic gap(input logic ser, output int o);
		logic prev;
		for (int k = 0; k < 3; k++) begin
			o = 0;
			prev = serial_clk;
			do begin
				@(posedge pclk);
				o++;
			end while ((ser ? serial_clk === prev : refresh_req !== 1'b1) && o < 3000);
			if (o >= 3000)
				stall();
		end
	endtask
	task automatic push(input logic [7:0] val);
		int n;
		n = 0;
		@(posedge pclk);
		in_valid <= 1'b1;
		in_data <= val;
		do begin
			@(posedge pclk);
			n++;
		end while (in_ready !== 1'b1 && n < 20);
		if (in_ready !== 1'b1)
			stall();
		in_valid <= 1'b0;
	endtask
	task automatic pop(input logic [7:0] val, input logic [19:0] a);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (out_valid !== 1'b1 && n < 20);
		if (out_valid !== 1'b1)
			stall();
		check("ch1 data", out_data, val);
		check("ch1 addr", out_addr, a);
		out_ready <= 1'b1;
		@(posedge pclk);
		out_ready <= 1'b0;
	endtask
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, ext_serial_clk, ext_req, s0rx, s1rx, s0tx, s1tx} = '0;
		{in_valid, out_ready, paddr, pwdata, in_data} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(8'h1f, 8'h00);
		rdchk(8'h14, 8'hff);
		rdchk(8'h15, 8'hff);
		wr(8'h1f, 8'ha5);
		rdchk(8'h1f, 8'ha5);
		check("cpu ctrl pins", cpu_ctrl, 8'ha5);
		wr(8'h16, 8'h5a);
		wr(8'h17, 8'hc3);
		rdchk(8'h16, 8'h5a);
		rdchk(8'h17, 8'hc3);
		xfer(1'b0, 8'h18, 8'h00);
		f = rd;
		wr(8'h18, f ^ 8'h80);
		check("frc write err", err, 1'b0);
		xfer(1'b0, 8'h18, 8'h00);
		g = rd;
		check("frc read only", 8'(f - g) <= 8'h02, 1'b1);
		xfer(1'b0, 8'h3e, 8'h00);
		check("unmapped err", err, 1'b1);
		check("unmapped data", rd, 8'h00);
		for (int c = 0; c < 3; c++) begin
			wr(8'h22, c[7:0]);
			wr(8'h25, c[7:0]);
			for (int p = 0; p < 2; p++) begin
				v = p[0] ? ~(3'b001 << c) : 3'b001 << c;
				{s1rx, s0rx, ext_req} <= v;
				{s1tx, s0tx} <= v[2:1];
				repeat (3) @(posedge pclk);
				check("source request", src_req, !p[0]);
				check("dest request", dst_req, !p[0]);
			end
		end
		wr(8'h23, 8'h34);
		wr(8'h24, 8'h12);
		wr(8'h25, 8'hff);
		check("dest addr", dest_addr, 20'h71234);
		rdchk(8'h25, 8'h07);
		wr(8'h26, 8'h78);
		wr(8'h27, 8'h56);
		check("ch0 count", cnt, 20'h05678);
		rdchk(8'h27, 8'h56);
		wr(8'h10, 8'hc0);
		repeat (2) @(posedge pclk);
		check("pin high", {oe, pin}, 2'h3);
		wr(8'h10, 8'h80);
		repeat (2) @(posedge pclk);
		check("pin low", {oe, pin}, 2'h2);
		wr(8'h16, 8'h03);
		wr(8'h17, 8'h00);
		wr(8'h14, 8'h00);
		wr(8'h15, 8'h00);
		wr(8'h10, 8'h42);
		d = 0;
		while (pin !== 1'b1 && d < 200) begin
			@(posedge pclk);
			d++;
		end
		check("pin toggle", pin, 1'b1);
		if (pin !== 1'b1)
			stall();
		xfer(1'b0, 8'h14, 8'h00);
		check("reloaded low", rd <= 8'h03, 1'b1);
		rdchk(8'h15, 8'h00);
		wr(8'h10, 8'h00);
		wr(8'h14, 8'h00);
		wr(8'h15, 8'h01);
		wr(8'h10, 8'h02);
		xfer(1'b0, 8'h14, 8'h00);
		f = rd;
		check("pin inhibited", oe, 1'b0);
		repeat (100) @(posedge pclk);
		rdchk(8'h15, f == 8'h00 ? 8'h01 : 8'h00);
		wr(8'h28, 8'h10);
		wr(8'h29, 8'h00);
		wr(8'h2a, 8'h00);
		wr(8'h2b, 8'h55);
		wr(8'h2c, 8'h66);
		wr(8'h2e, 8'h03);
		wr(8'h2f, 8'h00);
		for (int m = 0; m < 4; m++) begin
			// software keeps the wait-count bits of this register at zero
			wr(8'h31, 8'h80 | m[7:0]);
			check("direction", to_mem, m[1]);
		end
		wr(8'h31, 8'h81);
		push(8'ha1);
		push(8'hb2);
		@(posedge pclk);
		in_valid <= 1'b1;
		repeat (4) @(posedge pclk);
		check("buffer full", in_ready, 1'b0);
		in_valid <= 1'b0;
		pop(8'ha1, 20'h00010);
		pop(8'hb2, 20'h0000f);
		wr(8'h31, 8'h82);
		push(8'hd4);
		pop(8'hd4, 20'h0000e);
		check("io addr fixed", io_addr, 16'h6655);
		check("count spent", in_ready, 1'b0);
		for (int c = 0; c < 4; c++) begin
			wr(8'h36, 8'h80 | c[7:0]);
			gap(1'b0, d);
			check("refresh gap", 20'(d), 20'(10 << c));
		end
		for (int c = 0; c < 7; c++) begin
			wr(8'h0a, c[7:0]);
			gap(1'b1, d);
			check("serial half period", 20'(d), 20'(divs[c] / 2));
		end
		wr(8'h0a, 8'h07);
		for (int k = 0; k < 4; k++) begin
			ext_serial_clk <= ~k[0];
			repeat (3) @(posedge pclk);
			check("external clock", serial_clk, !k[0]);
		end
		conclude();
	end
endmodule
bind mprb_top mprb_checker #(.DATA_W(DATA_W)) chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.prdata, .pready, .pslverr, .shared_addr_timer_pin, .shared_addr_timer_oe, .refresh_req,
	.ch0_dest_addr, .cpu_control_register, .ch1_out_data, .ch1_out_addr, .ch1_out_valid,
	.ch1_out_ready);
